/* File: rsg_pkg.sv */
// Shared constants for the status and gain-control register bank
package rsg_pkg;

    ////////////////////////////////////////////////////////////////////////////
    // Register map, printed offsets
    localparam logic [7:0] RSG_ADDR_LINK_STATUS = 8'h1d;
    localparam logic [7:0] RSG_ADDR_GAIN_CONFIG = 8'h1e;
    localparam logic [7:0] RSG_ADDR_STATIC_GAIN = 8'h1f;

    ////////////////////////////////////////////////////////////////////////////
    // Link status field positions
    localparam int RSG_ST_PHASE_LSB = 24;
    localparam int RSG_ST_GEAR_LSB = 20;
    localparam int RSG_ST_PLL_BIT = 19;
    localparam int RSG_ST_CRC_BIT = 18;
    localparam int RSG_ST_OWN_BIT = 17;
    localparam int RSG_ST_EXT_BIT = 16;
    localparam int RSG_ST_FAULT_LSB = 13;
    localparam int RSG_ST_ARMED_BIT = 12;
    localparam int RSG_ST_TXBUSY_BIT = 11;
    localparam int RSG_ST_RXBUSY_BIT = 10;
    localparam int RSG_ST_GAIN_LSB = 0;

    ////////////////////////////////////////////////////////////////////////////
    // Gain configuration field positions and reset values
    localparam int RSG_CF_SETPOINT_LSB = 14;
    localparam int RSG_CF_PERIOD_LSB = 4;
    localparam int RSG_CF_SOURCE_BIT = 3;
    localparam int RSG_CF_LOAD_BIT = 2;
    localparam int RSG_CF_FIXCHOICE_BIT = 1;
    localparam int RSG_CF_LOOPON_BIT = 0;
    localparam logic [1:0] RSG_SETPOINT_RST = 2'h2;
    localparam logic [9:0] RSG_PERIOD_RST = 10'h200;
    localparam logic [9:0] RSG_PERIOD_MIN = 10'h004;
    localparam logic RSG_FIXCHOICE_RST = 1'b1;
    localparam logic RSG_LOOPON_RST = 1'b1;

    ////////////////////////////////////////////////////////////////////////////
    // Static gain register field positions
    localparam int RSG_SG_READER_LSB = 10;
    localparam int RSG_SG_CARD_LSB = 0;
    localparam logic [9:0] RSG_GAIN_RST = 10'h000;
    localparam logic [9:0] RSG_GAIN_MAX = 10'h3ff;

    ////////////////////////////////////////////////////////////////////////////
    // Carrier rate derived from the reference clock by a fractional accumulator
    localparam int RSG_REF_CLK_KHZ = 200000;
    localparam int RSG_CARRIER_KHZ = 13560;
    localparam logic [17:0] RSG_ACC_STEP = 18'(RSG_CARRIER_KHZ);
    localparam logic [17:0] RSG_ACC_WRAP = 18'(RSG_REF_CLK_KHZ);

    // Fault codes
    localparam logic [2:0] RSG_FAULT_NONE = 3'h0;
    localparam logic [2:0] RSG_FAULT_LAST = 3'h4;
    localparam logic [2:0] RSG_PHASE_RSVD = 3'h7;

    // Gain loop operating mode
    typedef enum logic [2:0] {
        RSG_MODE_LOOP = 3'b001,
        RSG_MODE_STATIC = 3'b010,
        RSG_MODE_FROZEN = 3'b100
    } rsg_mode_t;

endpackage : rsg_pkg

/* File: rsg_update_timer.sv */
`timescale 1ns/1ps
`default_nettype none
// Counts carrier ticks and fires once every (period + 1) ticks
module rsg_update_timer #(
    parameter int WIDTH = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic tick,
    input wire logic run,
    input wire logic [WIDTH-1:0] period,
    output logic fire
);

    logic [WIDTH-1:0] count_q;
    logic [WIDTH-1:0] count_d;
    logic fire_q;
    logic fire_d;

    // Restart from zero whenever the loop is stopped
    always_comb begin
        count_d = count_q;
        fire_d = 1'b0;
        if (!run) begin
            count_d = '0;
        end else if (tick) begin
            if (count_q >= period) begin
                count_d = '0;
                fire_d = 1'b1;
            end else begin
                count_d = count_q + WIDTH'(1);
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            count_q <= '0;
            fire_q <= 1'b0;
        end else begin
            count_q <= count_d;
            fire_q <= fire_d;
        end
    end

    assign fire = fire_q;

endmodule : rsg_update_timer
`default_nettype wire

/* File: rsg_level_filter.sv */
`timescale 1ns/1ps
`default_nettype none
// Accepts a level change only after it stood for DEPTH clock cycles
module rsg_level_filter #(
    parameter int DEPTH = 8
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic raw,
    output logic filtered
);

    localparam int CW = $clog2(DEPTH + 1);
    localparam logic [CW-1:0] LIMIT = CW'(DEPTH);

    logic [CW-1:0] run_q;
    logic [CW-1:0] run_d;
    logic level_q;
    logic level_d;

    // Short glitches reset the run and never reach the output
    always_comb begin
        run_d = run_q;
        level_d = level_q;
        if (raw == level_q) begin
            run_d = '0;
        end else if (run_q >= LIMIT - CW'(1)) begin
            run_d = '0;
            level_d = raw;
        end else begin
            run_d = run_q + CW'(1);
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            run_q <= '0;
            level_q <= 1'b0;
        end else begin
            run_q <= run_d;
            level_q <= level_d;
        end
    end

    assign filtered = level_q;

endmodule : rsg_level_filter
`default_nettype wire

/* File: rsg_status_gain_regs.sv */
`timescale 1ns/1ps
`default_nettype none
module rsg_status_gain_regs
    import rsg_pkg::*;
#(
    parameter int FILTER_DEPTH = 8,
    parameter int CRC_WIDTH = 16,
    parameter logic [CRC_WIDTH-1:0] CRC_RESIDUE = 16'h0000
) (
    input wire logic REF_CLK,
    input wire logic RSTN,
    // Register access port
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_RD,
    output logic [31:0] REG_RDATA,
    output logic REG_RVALID,
    // Live state of the surrounding logic
    input wire logic [2:0] TRX_PHASE,
    input wire logic [3:0] POWER_CONTROL_GEAR,
    input wire logic FIELD_ON,
    input wire logic CARRIER_FREQ_OK,
    input wire logic PLL_LOCKED,
    input wire logic [CRC_WIDTH-1:0] CRC_VALUE,
    input wire logic CRC_INVERTED,
    input wire logic DRIVERS_ON,
    input wire logic EXT_FIELD_RAW,
    input wire logic ACTIVE_MODE_FAULT_EVENT,
    input wire logic FAULT_STROBE,
    input wire logic [2:0] FAULT_CAUSE,
    input wire logic FIELD_DRIVE_ON_SET,
    input wire logic DECODER_ENABLED,
    input wire logic DECODER_READY,
    input wire logic ENCODER_SENDING,
    input wire logic DECODER_RECEIVING,
    input wire logic RX_LEVEL_HIGH,
    input wire logic RX_LEVEL_LOW,
    // Gain control outputs to the receive path
    output logic [9:0] RX_DIVIDER,
    output logic [1:0] GAIN_SETPOINT_SEL,
    output logic GAIN_UPDATE
);

    ////////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic rvalid_q;
    logic rvalid_d;
    logic [2:0] phase_q;
    logic [2:0] phase_d;
    logic [3:0] gear_q;
    logic [3:0] gear_d;
    logic pll_q;
    logic pll_d;
    logic crc_ok_q;
    logic crc_ok_d;
    logic own_q;
    logic own_d;
    logic armed_q;
    logic armed_d;
    logic tx_busy_q;
    logic tx_busy_d;
    logic rx_busy_q;
    logic rx_busy_d;
    logic [2:0] fault_q;
    logic [2:0] fault_d;
    logic ext_field;
    logic [1:0] setpoint_q;
    logic [1:0] setpoint_d;
    logic [9:0] period_q;
    logic [9:0] period_d;
    logic source_q;
    logic source_d;
    logic fix_choice_q;
    logic fix_choice_d;
    logic loop_on_q;
    logic loop_on_d;
    logic load_q;
    logic load_d;
    logic [9:0] reader_gain_q;
    logic [9:0] reader_gain_d;
    logic [9:0] card_gain_q;
    logic [9:0] card_gain_d;
    logic [9:0] gain_q;
    logic [9:0] gain_d;
    rsg_mode_t mode;
    logic [17:0] acc_q;
    logic [17:0] acc_d;
    logic carrier_tick_q;
    logic carrier_tick_d;
    logic update_fire;
    logic [9:0] static_gain;
    logic wr_config;
    logic wr_static;
    logic [31:0] status_word;
    logic [31:0] config_word;
    logic [31:0] static_word;

    ////////////////////////////////////////////////////////////////////////////
    // Address decode for writes
    assign wr_config = REG_WR && (REG_ADDR == RSG_ADDR_GAIN_CONFIG);
    assign wr_static = REG_WR && (REG_ADDR == RSG_ADDR_STATIC_GAIN);

    ////////////////////////////////////////////////////////////////////////////
    // Live status sampling, one flop deep so the read word is glitch free
    always_comb begin
        // The reserved phase code is passed through as is; the sequencer never drives it
        phase_d = TRX_PHASE;
        gear_d = POWER_CONTROL_GEAR;
        pll_d = FIELD_ON && CARRIER_FREQ_OK && PLL_LOCKED;
        // Residue compare only in inverted mode; mid-frame value means nothing
        if (CRC_INVERTED) begin
            crc_ok_d = (CRC_VALUE == CRC_RESIDUE);
        end else begin
            crc_ok_d = (CRC_VALUE == '0);
        end
        own_d = DRIVERS_ON;
        armed_d = DECODER_ENABLED && DECODER_READY;
        tx_busy_d = ENCODER_SENDING;
        rx_busy_d = DECODER_RECEIVING;
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            phase_q <= 3'h0;
            gear_q <= 4'h0;
            pll_q <= 1'b0;
            crc_ok_q <= 1'b0;
            own_q <= 1'b0;
            armed_q <= 1'b0;
            tx_busy_q <= 1'b0;
            rx_busy_q <= 1'b0;
        end else begin
            phase_q <= phase_d;
            gear_q <= gear_d;
            pll_q <= pll_d;
            crc_ok_q <= crc_ok_d;
            own_q <= own_d;
            armed_q <= armed_d;
            tx_busy_q <= tx_busy_d;
            rx_busy_q <= rx_busy_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // External field detector, debounced before it reaches the status word
    rsg_level_filter #(
        .DEPTH(FILTER_DEPTH)
    ) u_ext_filter (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .raw(EXT_FIELD_RAW),
        .filtered(ext_field)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Active-mode fault cause: a new fault beats a same-cycle drive-on clear
    always_comb begin
        fault_d = fault_q;
        if (FIELD_DRIVE_ON_SET) begin
            fault_d = RSG_FAULT_NONE;
        end
        if (FAULT_STROBE) begin
            // Reserved cause codes are dropped rather than latched
            if (FAULT_CAUSE <= RSG_FAULT_LAST) begin
                fault_d = FAULT_CAUSE;
            end
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            fault_q <= RSG_FAULT_NONE;
        end else begin
            fault_q <= fault_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Configuration and static gain registers; the load bit is a pulse only
    always_comb begin
        setpoint_d = setpoint_q;
        period_d = period_q;
        source_d = source_q;
        fix_choice_d = fix_choice_q;
        loop_on_d = loop_on_q;
        load_d = 1'b0;
        reader_gain_d = reader_gain_q;
        card_gain_d = card_gain_q;
        if (wr_config) begin
            setpoint_d = REG_WDATA[RSG_CF_SETPOINT_LSB +: 2];
            period_d = REG_WDATA[RSG_CF_PERIOD_LSB +: 10];
            source_d = REG_WDATA[RSG_CF_SOURCE_BIT];
            load_d = REG_WDATA[RSG_CF_LOAD_BIT];
            fix_choice_d = REG_WDATA[RSG_CF_FIXCHOICE_BIT];
            loop_on_d = REG_WDATA[RSG_CF_LOOPON_BIT];
        end
        if (wr_static) begin
            reader_gain_d = REG_WDATA[RSG_SG_READER_LSB +: 10];
            card_gain_d = REG_WDATA[RSG_SG_CARD_LSB +: 10];
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            setpoint_q <= RSG_SETPOINT_RST;
            period_q <= RSG_PERIOD_RST;
            source_q <= 1'b0;
            fix_choice_q <= RSG_FIXCHOICE_RST;
            loop_on_q <= RSG_LOOPON_RST;
            load_q <= 1'b0;
            reader_gain_q <= RSG_GAIN_RST;
            card_gain_q <= RSG_GAIN_RST;
        end else begin
            setpoint_q <= setpoint_d;
            period_q <= period_d;
            source_q <= source_d;
            fix_choice_q <= fix_choice_d;
            loop_on_q <= loop_on_d;
            load_q <= load_d;
            reader_gain_q <= reader_gain_d;
            card_gain_q <= card_gain_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Carrier-rate enable: fractional accumulator keeps the mean rate exact,
    // at the cost of one reference cycle of jitter per tick
    always_comb begin
        acc_d = acc_q + RSG_ACC_STEP;
        carrier_tick_d = 1'b0;
        if (acc_d >= RSG_ACC_WRAP) begin
            acc_d = acc_d - RSG_ACC_WRAP;
            carrier_tick_d = 1'b1;
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            acc_q <= 18'h00000;
            carrier_tick_q <= 1'b0;
        end else begin
            acc_q <= acc_d;
            carrier_tick_q <= carrier_tick_d;
        end
    end

    // Update period timer; values below the minimum are clamped, not trusted
    rsg_update_timer #(
        .WIDTH(10)
    ) u_update_timer (
        .clk(REF_CLK),
        .rst_n(RSTN),
        .tick(carrier_tick_q),
        .run(loop_on_q),
        .period((period_q < RSG_PERIOD_MIN) ? RSG_PERIOD_MIN : period_q),
        .fire(update_fire)
    );

    ////////////////////////////////////////////////////////////////////////////
    // Gain loop mode and divider value
    assign static_gain = source_q ? reader_gain_q : card_gain_q;

    always_comb begin
        if (loop_on_q) begin
            mode = RSG_MODE_LOOP;
        end else if (fix_choice_q) begin
            mode = RSG_MODE_FROZEN;
        end else begin
            mode = RSG_MODE_STATIC;
        end
    end

    // A load strobe always wins; otherwise the mode decides
    always_comb begin
        gain_d = gain_q;
        if (load_q) begin
            gain_d = static_gain;
        end else begin
            unique case (mode)
                RSG_MODE_LOOP: begin
                    if (update_fire && RX_LEVEL_HIGH && gain_q != RSG_GAIN_MAX) begin
                        gain_d = gain_q + 10'h001;
                    end else if (update_fire && RX_LEVEL_LOW && gain_q != RSG_GAIN_RST) begin
                        gain_d = gain_q - 10'h001;
                    end
                end
                RSG_MODE_STATIC: begin
                    // Holds the divider; the static register reaches it only through a load strobe
                    gain_d = gain_q;
                end
                RSG_MODE_FROZEN: begin
                    gain_d = gain_q;
                end
                default: begin
                    gain_d = gain_q;
                end
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            gain_q <= RSG_GAIN_RST;
        end else begin
            gain_q <= gain_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Read words; reserved bits are constant zero
    always_comb begin
        status_word = 32'h00000000;
        status_word[RSG_ST_PHASE_LSB +: 3] = phase_q;
        status_word[RSG_ST_GEAR_LSB +: 4] = gear_q;
        status_word[RSG_ST_PLL_BIT] = pll_q;
        status_word[RSG_ST_CRC_BIT] = crc_ok_q;
        status_word[RSG_ST_OWN_BIT] = own_q;
        status_word[RSG_ST_EXT_BIT] = ext_field;
        // Cause only shown while the event is up
        status_word[RSG_ST_FAULT_LSB +: 3] =
            ACTIVE_MODE_FAULT_EVENT ? fault_q : RSG_FAULT_NONE;
        status_word[RSG_ST_ARMED_BIT] = armed_q;
        status_word[RSG_ST_TXBUSY_BIT] = tx_busy_q;
        status_word[RSG_ST_RXBUSY_BIT] = rx_busy_q;
        status_word[RSG_ST_GAIN_LSB +: 10] = gain_q;
        config_word = 32'h00000000;
        config_word[RSG_CF_SETPOINT_LSB +: 2] = setpoint_q;
        config_word[RSG_CF_PERIOD_LSB +: 10] = period_q;
        config_word[RSG_CF_SOURCE_BIT] = source_q;
        config_word[RSG_CF_FIXCHOICE_BIT] = fix_choice_q;
        config_word[RSG_CF_LOOPON_BIT] = loop_on_q;
        static_word = 32'h00000000;
        static_word[RSG_SG_READER_LSB +: 10] = reader_gain_q;
        static_word[RSG_SG_CARD_LSB +: 10] = card_gain_q;
    end

    // Registered read answer, unmapped addresses read zero
    always_comb begin
        rvalid_d = REG_RD;
        rdata_d = rdata_q;
        if (REG_RD) begin
            unique case (REG_ADDR)
                RSG_ADDR_LINK_STATUS: rdata_d = status_word;
                RSG_ADDR_GAIN_CONFIG: rdata_d = config_word;
                RSG_ADDR_STATIC_GAIN: rdata_d = static_word;
                default: rdata_d = 32'h00000000;
            endcase
        end
    end

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rdata_q <= 32'h00000000;
            rvalid_q <= 1'b0;
        end else begin
            rdata_q <= rdata_d;
            rvalid_q <= rvalid_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Outputs
    assign REG_RDATA = rdata_q;
    assign REG_RVALID = rvalid_q;
    assign RX_DIVIDER = gain_q;
    assign GAIN_SETPOINT_SEL = setpoint_q;
    assign GAIN_UPDATE = update_fire;

endmodule : rsg_status_gain_regs
`default_nettype wire

/* File: rsg_status_gain_regs_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// Port-level checks on the status and gain-control register bank
module rsg_status_gain_regs_sva (
    input wire logic REF_CLK,
    input wire logic RSTN,
    input wire logic [7:0] REG_ADDR,
    input wire logic REG_WR,
    input wire logic [31:0] REG_WDATA,
    input wire logic REG_RD,
    input wire logic [31:0] REG_RDATA,
    input wire logic [2:0] TRX_PHASE,
    input wire logic [3:0] POWER_CONTROL_GEAR,
    input wire logic FIELD_ON,
    input wire logic CARRIER_FREQ_OK,
    input wire logic PLL_LOCKED,
    input wire logic [15:0] CRC_VALUE,
    input wire logic DRIVERS_ON,
    input wire logic ACTIVE_MODE_FAULT_EVENT,
    input wire logic DECODER_ENABLED,
    input wire logic DECODER_READY,
    input wire logic ENCODER_SENDING,
    input wire logic DECODER_RECEIVING,
    input wire logic [9:0] RX_DIVIDER,
    input wire logic [1:0] GAIN_SETPOINT_SEL,
    input wire logic GAIN_UPDATE
);
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    ////////////////////////////////////////////////////////////////////////////
    // Decoded accesses and live-state summaries
    wire logic st_rd = REG_RD && REG_ADDR == 8'h1d;
    wire logic cfg_wr = REG_WR && REG_ADDR == 8'h1e;
    wire logic pll_all = FIELD_ON && CARRIER_FREQ_OK && PLL_LOCKED;
    wire logic crc_zero = CRC_VALUE == 16'h0000; // Residue is zero by default
    wire logic [2:0] act = {DECODER_ENABLED && DECODER_READY, ENCODER_SENDING, DECODER_RECEIVING};
    wire logic [1:0] wsp = REG_WDATA[15:14];

    ////////////////////////////////////////////////////////////////////////////
    // Status word mirrors inputs from two edges before the data edge; the gain field mirrors RX_DIVIDER from one edge before
    AST_PHASE: assert property (st_rd |=> REG_RDATA[26:24] == $past(TRX_PHASE, 2))
        else $error("status phase field wrong");
    AST_GEAR: assert property (st_rd |=> REG_RDATA[23:20] == $past(POWER_CONTROL_GEAR, 2))
        else $error("status gear field wrong");
    AST_PLL: assert property (st_rd |=> REG_RDATA[19] == $past(pll_all, 2))
        else $error("status pll bit wrong");
    AST_CRC: assert property (st_rd |=> REG_RDATA[18] == $past(crc_zero, 2))
        else $error("status checksum bit wrong");
    AST_OWN: assert property (st_rd |=> REG_RDATA[17] == $past(DRIVERS_ON, 2))
        else $error("status own field bit wrong");
    AST_ACT: assert property (st_rd |=> REG_RDATA[12:10] == $past(act, 2))
        else $error("status activity bits wrong");
    AST_GAIN: assert property (st_rd |=> REG_RDATA[9:0] == $past(RX_DIVIDER))
        else $error("status gain field not live");
    AST_FAULT: assert property (st_rd && !ACTIVE_MODE_FAULT_EVENT |=> REG_RDATA[15:13] == 3'h0)
        else $error("fault code shown without event");
    AST_RSVD: assert property (st_rd |=> REG_RDATA[31:27] == 5'h00)
        else $error("status reserved bits not zero");
    AST_SETPOINT: assert property (cfg_wr |=> GAIN_SETPOINT_SEL == $past(wsp))
        else $error("setpoint output not written value");
    // Shortest legal period is five carrier ticks, far above eight clocks
    AST_SPACING: assert property (GAIN_UPDATE |=> !GAIN_UPDATE [*8])
        else $error("gain updates too close");
endmodule : rsg_status_gain_regs_sva

bind rsg_status_gain_regs rsg_status_gain_regs_sva rsg_status_gain_regs_sva_inst (.*);
`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none
module tb;
    logic REF_CLK, RSTN, REG_WR, REG_RD, REG_RVALID, GAIN_UPDATE;
    logic [7:0] REG_ADDR;
    logic [31:0] REG_WDATA, REG_RDATA, rd_q;
    logic [2:0] TRX_PHASE, FAULT_CAUSE;
    logic [3:0] POWER_CONTROL_GEAR;
    logic [15:0] CRC_VALUE;
    logic [9:0] RX_DIVIDER;
    logic [1:0] GAIN_SETPOINT_SEL;
    logic FIELD_ON, CARRIER_FREQ_OK, PLL_LOCKED, CRC_INVERTED, DRIVERS_ON, EXT_FIELD_RAW;
    logic ACTIVE_MODE_FAULT_EVENT, FAULT_STROBE, FIELD_DRIVE_ON_SET, DECODER_ENABLED;
    logic DECODER_READY, ENCODER_SENDING, DECODER_RECEIVING, RX_LEVEL_HIGH, RX_LEVEL_LOW;
    int bad_count = 0;
    int cmp_count = 0;

    rsg_status_gain_regs rsg_status_gain_regs_inst (.*);

    ////////////////////////////////////////////////////////////////////////////
    // Shared helpers
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            bad_count++;
            $display("Error %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge REF_CLK);
        REG_WR <= 1'b1;
        REG_ADDR <= a;
        REG_WDATA <= d;
        @(posedge REF_CLK);
        REG_WR <= 1'b0;
    endtask : wr

    // Answer is registered, so sample just after the taking edge
    task automatic rd(input logic [7:0] a);
        @(posedge REF_CLK);
        REG_RD <= 1'b1;
        REG_ADDR <= a;
        @(posedge REF_CLK);
        REG_RD <= 1'b0;
        #1;
        rd_q = REG_RDATA;
        check("read valid", {31'h0, REG_RVALID}, 32'h1);
    endtask : rd

    function automatic logic [31:0] cfg(input logic [1:0] sp, input logic [9:0] per,
                                        input logic [3:0] low);
        return {16'h0000, sp, per, low};
    endfunction : cfg

    ////////////////////////////////////////////////////////////////////////////
    // Scenarios
    task automatic t_reset();
        rd(8'h1e);
        check("config reset", rd_q, 32'h0000a003);
        rd(8'h1f);
        check("static gain reset", rd_q, 32'h00000000);
        rd(8'h1d);
        check("status reset", rd_q, 32'h00040000);
        rd(8'h33);
        check("unmapped read", rd_q, 32'h00000000);
        check("setpoint reset", {30'h0, GAIN_SETPOINT_SEL}, 32'h2);
        $display("t_reset done");
    endtask : t_reset

    // Each pass sets a different mix of status sources
    task automatic t_status();
        logic [31:0] e;
        for (int i = 0; i < 7; i++) begin
            @(posedge REF_CLK);
            TRX_PHASE <= 3'(i);
            POWER_CONTROL_GEAR <= 4'(15 - i);
            {FIELD_ON, CARRIER_FREQ_OK, PLL_LOCKED} <= 3'(i + 1);
            {DRIVERS_ON, ENCODER_SENDING, DECODER_RECEIVING} <= 3'(i);
            {DECODER_ENABLED, DECODER_READY} <= 2'(i + 1);
            CRC_VALUE <= i[0] ? 16'h0000 : 16'h00a5;
            rd(8'h1d);
            e = {5'h0, 3'(i), 4'(15 - i), i == 6, i[0], i[2], 1'b0, 3'h0,
                 2'(i + 1) == 2'h3, i[1], i[0], 10'h000};
            check("status word", rd_q, e);
        end
        $display("t_status done");
    endtask : t_status

    task automatic t_fault();
        for (int c = 1; c < 5; c++) begin
            @(posedge REF_CLK);
            ACTIVE_MODE_FAULT_EVENT <= 1'b1;
            FAULT_STROBE <= 1'b1;
            FAULT_CAUSE <= 3'(c);
            @(posedge REF_CLK);
            FAULT_STROBE <= 1'b0;
            rd(8'h1d);
            check("fault code", {29'h0, rd_q[15:13]}, 32'(c));
        end
        @(posedge REF_CLK);
        ACTIVE_MODE_FAULT_EVENT <= 1'b0;
        rd(8'h1d);
        check("fault hidden", {29'h0, rd_q[15:13]}, 32'h0);
        @(posedge REF_CLK);
        ACTIVE_MODE_FAULT_EVENT <= 1'b1;
        FIELD_DRIVE_ON_SET <= 1'b1;
        @(posedge REF_CLK);
        FIELD_DRIVE_ON_SET <= 1'b0;
        rd(8'h1d);
        check("fault cleared", {29'h0, rd_q[15:13]}, 32'h0);
        $display("t_fault done");
    endtask : t_fault

    task automatic t_ext();
        @(posedge REF_CLK);
        EXT_FIELD_RAW <= 1'b1;
        rd(8'h1d);
        check("ext field early", {31'h0, rd_q[16]}, 32'h0);
        repeat (20) @(posedge REF_CLK);
        rd(8'h1d);
        check("ext field filtered", {31'h0, rd_q[16]}, 32'h1);
        $display("t_ext done");
    endtask : t_ext

    // Static values differ so a wrong source pick shows up
    task automatic t_load();
        wr(8'h1f, 32'h000a955a);
        rd(8'h1f);
        check("static gain", rd_q, 32'h000a955a);
        wr(8'h1e, cfg(2'h2, 10'h200, 4'h4));
        repeat (3) @(posedge REF_CLK);
        check("card load", {22'h0, RX_DIVIDER}, 32'h15a);
        wr(8'h1d, 32'hffffffff);
        rd(8'h1e);
        check("load self clear", rd_q, cfg(2'h2, 10'h200, 4'h0));
        wr(8'h1e, cfg(2'h2, 10'h200, 4'hc));
        rd(8'h1d);
        check("reader load", {22'h0, rd_q[9:0]}, 32'h2a5);
        wr(8'h1f, 32'h00000000);
        wr(8'h1e, cfg(2'h2, 10'h200, 4'h8));
        repeat (3) @(posedge REF_CLK);
        check("no reload", {22'h0, RX_DIVIDER}, 32'h2a5);
        $display("t_load done");
    endtask : t_load

    // Minimum period spans five carrier ticks, 73 or 74 clocks at this rate
    task automatic t_loop();
        int n;
        int m;
        RX_LEVEL_HIGH <= 1'b1;
        wr(8'h1e, cfg(2'h1, 10'h004, 4'h1));
        #1;
        check("setpoint sel", {30'h0, GAIN_SETPOINT_SEL}, 32'h1);
        n = 0;
        while (GAIN_UPDATE !== 1'b1 && n < 200) begin
            @(posedge REF_CLK);
            #1;
            n++;
        end
        m = 0;
        do begin
            @(posedge REF_CLK);
            #1;
            m++;
        end while (GAIN_UPDATE !== 1'b1 && m < 200);
        check("update spacing", {31'h0, m == 73 || m == 74}, 32'h1);
        repeat (2) @(posedge REF_CLK);
        check("loop steps", {22'h0, RX_DIVIDER}, 32'h2a7);
        wr(8'h1e, cfg(2'h1, 10'h004, 4'h2));
        n = 0;
        repeat (200) begin
            @(posedge REF_CLK);
            #1;
            n += int'(GAIN_UPDATE === 1'b1);
        end
        check("loop off quiet", 32'(n), 32'h0);
        check("loop off frozen", {22'h0, RX_DIVIDER}, 32'h2a7);
        $display("t_loop done");
    endtask : t_loop

    task automatic close_out();
        $display("Comparisons %0d mismatches %0d", cmp_count, bad_count);
        if (bad_count == 0 && cmp_count > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : close_out

    ////////////////////////////////////////////////////////////////////////////
    // Clock, reset, sequence and watchdog
    initial begin
        REF_CLK = 1'b0;
        forever #2.5 REF_CLK = ~REF_CLK;
    end

    initial begin
        {RSTN, REG_WR, REG_RD, REG_ADDR, REG_WDATA, TRX_PHASE, FAULT_CAUSE} = '0;
        {POWER_CONTROL_GEAR, CRC_VALUE, FIELD_ON, CARRIER_FREQ_OK, PLL_LOCKED} = '0;
        {CRC_INVERTED, DRIVERS_ON, EXT_FIELD_RAW, ACTIVE_MODE_FAULT_EVENT, FAULT_STROBE} = '0;
        {FIELD_DRIVE_ON_SET, DECODER_ENABLED, DECODER_READY, ENCODER_SENDING} = '0;
        {DECODER_RECEIVING, RX_LEVEL_HIGH, RX_LEVEL_LOW} = '0;
        repeat (16) @(posedge REF_CLK);
        RSTN <= 1'b1;
        t_reset();
        t_status();
        t_fault();
        t_ext();
        t_load();
        t_loop();
        close_out();
    end

    // Whole run needs well under two thousand clocks
    initial begin
        repeat (20000) @(posedge REF_CLK);
        bad_count++;
        close_out();
    end
endmodule : tb
`default_nettype wire
